/* hdl/rtcsp_pkg.sv */
/*
 Constants shared by both ends of the two-wire clock port.
 Assumes a single 20 MHz system clock on each end.
*/
// Functional notes
// - START then slave address; only own address
// - Eight bytes: seconds through calibration order
// - Power fail aborts access, clears pointer
// - Bus inputs ignored while power failed
// - Master starts only on idle bus
// - Data fall while clock high: START
// - Data rise while clock high: STOP
// - Data changes only while clock low
// - Transfers have no byte count limit
// - Eight bits then receiver-driven low acknowledge
// - Device acknowledges every received byte
// - Master nacks last read byte; device releases
// - Random read: write address, restart, read
// - Pointer advances only on acknowledge clock
// - Read continues incrementing until STOP; code stops incrementing at the master's nack
// - Freeze user copy while clock address held
// - Current-address read starts at pointer
// - Write: first byte pointer, then data bytes
// - Acknowledge address, word address, data
// - Below switchover: battery, low-current mode
// - Writes blocked for recovery interval
// - Clock location write resets divider chain
package rtcsp_pkg;
	localparam logic [6:0] SLAVE_ADDR = 7'h68;
	localparam logic [2:0] LAST_CLOCK_ADDR = 3'h6;
	localparam logic [2:0] CAL_ADDR = 3'h7;
	localparam int NUM_REGS = 8;
	localparam int CLK_HZ = 20000000;
	localparam int REC_US = 1000;
	localparam int REC_CYCLES = REC_US * (CLK_HZ / 1000000);
	localparam int HALF_BIT_NS = 1250;
	localparam int HALF_BIT_CYCLES = (HALF_BIT_NS * (CLK_HZ / 1000000)) / 1000;
endpackage

/* hdl/rtcsp_bus_if.sv */
/*
 Two-wire bus between the master end and the clock port.
 Assumes open-drain lines with pull-ups; enable high means pull low.
*/
`timescale 1ns/100ps
`default_nettype none
interface rtcsp_bus_if;
	logic scl_oe_m;
	logic sda_oe_m;
	logic sda_oe_s;
	logic scl;
	logic sda;
	assign scl = ~scl_oe_m;
	assign sda = ~(sda_oe_m | sda_oe_s);
	modport master (output scl_oe_m, output sda_oe_m, input scl, input sda);
	modport slave (output sda_oe_s, input scl, input sda);
endinterface
`default_nettype wire

/* hdl/rtcsp_slave.sv */
/*
 Clock port slave end: start/stop detect, address match, pointer and
 eight byte registers. Assumes bus lines are asynchronous to clk and
 power-fail and switchover levels come from analog comparators.
*/
`timescale 1ns/100ps
`default_nettype none
module rtcsp_slave (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic clk_en,
	rtcsp_bus_if.slave bus,
	input wire logic power_fail,
	input wire logic below_switchover,
	output logic freeze_update,
	output logic divider_reset,
	output logic low_current_mode,
	output logic [7:0] user_byte [8],
	output logic [2:0] word_address_value
);
	typedef enum logic [5:0] {
		S_IDLE = 6'b000001,
		S_ADDR = 6'b000010,
		S_PTR = 6'b000100,
		S_WDATA = 6'b001000,
		S_RDATA = 6'b010000,
		S_IGNORE = 6'b100000
	} rtcsp_state_t;

	rtcsp_state_t state;
	logic [2:0] scl_sync;
	logic [2:0] sda_sync;
	logic [1:0] pf_sync;
	logic [1:0] bs_sync;
	logic [3:0] bitcnt;
	logic [7:0] shreg;
	logic ack_phase;
	logic clock_write_seen;
	logic [$clog2(rtcsp_pkg::REC_CYCLES+1)-1:0] rec_cnt;
	logic [7:0] regs [8];

	// Two-flop sync; third stage for edges
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			scl_sync <= 3'h7;
			sda_sync <= 3'h7;
			pf_sync <= 2'h0;
			bs_sync <= 2'h0;
		end else if (clk_en) begin
			scl_sync <= {scl_sync[1:0], bus.scl};
			sda_sync <= {sda_sync[1:0], bus.sda};
			pf_sync <= {pf_sync[0], power_fail};
			bs_sync <= {bs_sync[0], below_switchover};
		end
	end

	wire logic scl_s = scl_sync[1];
	wire logic sda_s = sda_sync[1];
	// Comparator levels after their two flops
	wire logic pwr_fail_s = pf_sync[1];
	wire logic below_so_s = bs_sync[1];
	wire logic live = !pwr_fail_s;
	wire logic scl_rise = live && scl_s && !scl_sync[2];
	wire logic scl_fall = live && !scl_s && scl_sync[2];
	wire logic start_c = live && scl_s && scl_sync[2] && !sda_s && sda_sync[2];
	wire logic stop_c = live && scl_s && scl_sync[2] && sda_s && !sda_sync[2];
	wire logic write_ok = rec_cnt == '0;

	function automatic logic [2:0] ptr_inc(input logic [2:0] p);
		return (p == rtcsp_pkg::CAL_ADDR) ? 3'h0 : p + 3'h1;
	endfunction

	// Recovery interval holds writes off
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rec_cnt <= '0;
		end else if (clk_en) begin
			if (below_so_s || pwr_fail_s) begin
				rec_cnt <= ($bits(rec_cnt))'(rtcsp_pkg::REC_CYCLES);
			end else if (rec_cnt != '0) begin
				rec_cnt <= rec_cnt - 1'b1;
			end
		end
	end

	assign low_current_mode = below_so_s;

	// Protocol engine
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= S_IDLE;
			bitcnt <= 4'h0;
			shreg <= 8'h00;
			ack_phase <= 1'b0;
			bus.sda_oe_s <= 1'b0;
			word_address_value <= 3'h0;
			clock_write_seen <= 1'b0;
			divider_reset <= 1'b0;
			for (int i = 0; i < rtcsp_pkg::NUM_REGS; i++) begin
				regs[i] <= 8'h00;
			end
		end else if (clk_en) begin
			divider_reset <= 1'b0;
			if (pwr_fail_s) begin
				state <= S_IDLE;
				bus.sda_oe_s <= 1'b0;
				word_address_value <= 3'h0;
				clock_write_seen <= 1'b0;
			end else if (start_c) begin
				state <= S_ADDR;
				bitcnt <= 4'h0;
				ack_phase <= 1'b0;
				bus.sda_oe_s <= 1'b0;
			end else if (stop_c) begin
				state <= S_IDLE;
				bus.sda_oe_s <= 1'b0;
				divider_reset <= clock_write_seen;
				clock_write_seen <= 1'b0;
			end else if (scl_rise && !ack_phase && state != S_IDLE && state != S_IGNORE) begin
				shreg <= {shreg[6:0], sda_s};
				bitcnt <= bitcnt + 4'h1;
			end else if (scl_rise && ack_phase && state == S_RDATA) begin
				if (!sda_s) begin
					word_address_value <= ptr_inc(word_address_value);
				end else begin
					state <= S_IGNORE;
				end
			end else if (scl_fall) begin
				unique case (state)
				S_IDLE, S_IGNORE: begin
					bus.sda_oe_s <= 1'b0;
				end
				S_ADDR: begin
					if (ack_phase) begin
						ack_phase <= 1'b0;
						bitcnt <= 4'h0;
						if (shreg[0]) begin
							state <= S_RDATA;
							bus.sda_oe_s <= !regs[word_address_value][7];
						end else begin
							state <= S_PTR;
							bus.sda_oe_s <= 1'b0;
						end
					end else if (bitcnt == 4'h8) begin
						if (shreg[7:1] == rtcsp_pkg::SLAVE_ADDR) begin
							ack_phase <= 1'b1;
							bus.sda_oe_s <= 1'b1;
						end else begin
							state <= S_IGNORE;
						end
					end
				end
				S_PTR, S_WDATA: begin
					if (ack_phase) begin
						ack_phase <= 1'b0;
						bitcnt <= 4'h0;
						bus.sda_oe_s <= 1'b0;
						if (state == S_PTR) begin
							word_address_value <= shreg[2:0];
							state <= S_WDATA;
						end else begin
							word_address_value <= ptr_inc(word_address_value);
						end
					end else if (bitcnt == 4'h8) begin
						ack_phase <= 1'b1;
						bus.sda_oe_s <= 1'b1;
						if (state == S_WDATA && write_ok) begin
							regs[word_address_value] <= shreg;
							if (word_address_value <= rtcsp_pkg::LAST_CLOCK_ADDR) begin
								clock_write_seen <= 1'b1;
							end
						end
					end
				end
				S_RDATA: begin
					if (ack_phase) begin
						ack_phase <= 1'b0;
						bitcnt <= 4'h0;
						bus.sda_oe_s <= !regs[word_address_value][7];
					end else if (bitcnt == 4'h8) begin
						ack_phase <= 1'b1;
						bus.sda_oe_s <= 1'b0;
					end else begin
						bus.sda_oe_s <= !regs[word_address_value][3'h7 - bitcnt[2:0]];
					end
				end
				default: begin
					state <= S_IDLE;
				end
				endcase
			end
		end
	end

	// Freeze while a clock address is pointed at inside a transfer
	assign freeze_update = (state != S_IDLE) && (state != S_IGNORE) &&
		(word_address_value <= rtcsp_pkg::LAST_CLOCK_ADDR);

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			user_byte[i] = regs[i];
		end
	end
endmodule
`default_nettype wire

/* hdl/rtcsp_master.sv */
/*
 Bus master end: one command per request, write or read of a byte run.
 Assumes requests come from logic on clk; bus inputs are synchronised.
*/
`timescale 1ns/100ps
`default_nettype none
module rtcsp_master (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic clk_en,
	rtcsp_bus_if.master bus,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_read,
	input wire logic req_set_ptr,
	input wire logic [2:0] req_ptr,
	input wire logic [3:0] req_count,
	input wire logic [7:0] wr_data,
	output logic wr_take,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic nack_seen
);
	typedef enum logic [4:0] {
		M_IDLE = 5'b00001,
		M_START = 5'b00010,
		M_BITS = 5'b00100,
		M_ACK = 5'b01000,
		M_STOP = 5'b10000
	} rtcsp_mstate_t;

	rtcsp_mstate_t state;
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic [$clog2(rtcsp_pkg::HALF_BIT_CYCLES+1)-1:0] tick;
	logic [1:0] phase;
	logic [2:0] bitn;
	logic [7:0] shreg;
	logic [1:0] stage;
	logic [3:0] left;
	logic rd_mode;
	logic set_ptr;
	logic [2:0] ptr;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
		end else if (clk_en) begin
			scl_sync <= {scl_sync[0], bus.scl};
			sda_sync <= {sda_sync[0], bus.sda};
		end
	end

	wire logic bus_idle = scl_sync[1] && sda_sync[1];
	wire logic step = tick == '0;
	assign req_ready = (state == M_IDLE) && bus_idle;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tick <= '0;
		end else if (clk_en) begin
			tick <= (state == M_IDLE || step) ?
				($bits(tick))'(rtcsp_pkg::HALF_BIT_CYCLES - 1) : tick - 1'b1;
		end
	end

	// Stage: 0 address, 1 pointer, 2 data
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= M_IDLE;
			bus.scl_oe_m <= 1'b0;
			bus.sda_oe_m <= 1'b0;
			phase <= 2'h0;
			bitn <= 3'h0;
			shreg <= 8'h00;
			stage <= 2'h0;
			left <= 4'h0;
			rd_mode <= 1'b0;
			set_ptr <= 1'b0;
			ptr <= 3'h0;
			wr_take <= 1'b0;
			rd_valid <= 1'b0;
			rd_data <= 8'h00;
			nack_seen <= 1'b0;
		end else if (clk_en) begin
			wr_take <= 1'b0;
			rd_valid <= 1'b0;
			unique case (state)
			M_IDLE: begin
				if (req_valid && req_ready) begin
					rd_mode <= req_read;
					set_ptr <= req_set_ptr || !req_read;
					ptr <= req_ptr;
					left <= req_count;
					nack_seen <= 1'b0;
					state <= M_START;
					phase <= 2'h0;
				end
			end
			M_START: if (step) begin
				phase <= phase + 2'h1;
				if (phase == 2'h0) begin
					bus.sda_oe_m <= 1'b0;
					bus.scl_oe_m <= 1'b0;
				end else if (phase == 2'h1) begin
					bus.sda_oe_m <= 1'b1;
				end else begin
					bus.scl_oe_m <= 1'b1;
					shreg <= {rtcsp_pkg::SLAVE_ADDR, rd_mode && !set_ptr};
					stage <= 2'h0;
					bitn <= 3'h0;
					phase <= 2'h0;
					state <= M_BITS;
				end
			end
			M_BITS: if (step) begin
				phase <= phase + 2'h1;
				if (phase == 2'h0) begin
					bus.sda_oe_m <= (stage == 2'h2 && rd_mode) ? 1'b0 : !shreg[7];
				end else if (phase == 2'h1) begin
					bus.scl_oe_m <= 1'b0;
				end else if (phase == 2'h2) begin
					shreg <= {shreg[6:0], sda_sync[1]};
				end else begin
					bus.scl_oe_m <= 1'b1;
					bitn <= bitn + 3'h1;
					phase <= 2'h0;
					if (bitn == 3'h7) begin
						state <= M_ACK;
					end
				end
			end
			M_ACK: if (step) begin
				phase <= phase + 2'h1;
				if (phase == 2'h0) begin
					bus.sda_oe_m <= (stage == 2'h2 && rd_mode) ? (left > 4'h1) : 1'b0;
					if (stage == 2'h2 && rd_mode) begin
						rd_data <= shreg;
						rd_valid <= 1'b1;
					end
				end else if (phase == 2'h1) begin
					bus.scl_oe_m <= 1'b0;
				end else if (phase == 2'h2) begin
					if (!(stage == 2'h2 && rd_mode) && sda_sync[1]) begin
						nack_seen <= 1'b1;
					end
				end else begin
					bus.scl_oe_m <= 1'b1;
					phase <= 2'h0;
					bitn <= 3'h0;
					if (nack_seen) begin
						state <= M_STOP;
					end else if (stage == 2'h0) begin
						stage <= rd_mode && !set_ptr ? 2'h2 : 2'h1;
						shreg <= rd_mode && !set_ptr ? 8'h00 : {5'h00, ptr};
						state <= M_BITS;
					end else if (stage == 2'h1 && rd_mode) begin
						set_ptr <= 1'b0;
						state <= M_START;
					end else if (stage == 2'h2 && left <= 4'h1) begin
						state <= M_STOP;
					end else begin
						if (stage == 2'h2) begin
							left <= left - 4'h1;
						end
						stage <= 2'h2;
						shreg <= wr_data;
						wr_take <= !rd_mode && (left != 4'h0);
						state <= (left == 4'h0) ? M_STOP : M_BITS;
					end
				end
			end
			M_STOP: if (step) begin
				phase <= phase + 2'h1;
				if (phase == 2'h0) begin
					bus.sda_oe_m <= 1'b1;
				end else if (phase == 2'h1) begin
					bus.scl_oe_m <= 1'b0;
				end else if (phase == 2'h2) begin
					bus.sda_oe_m <= 1'b0;
				end else begin
					phase <= 2'h0;
					state <= M_IDLE;
				end
			end
			default: begin
				state <= M_IDLE;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

/* test/rtcsp_bus_sva.sv */
/*
 Checks on the two-wire bus lines between master and slave ends.
 Assumes instantiation in tb_top beside the bus interface.
*/
`timescale 1ns/100ps
`default_nettype none
module rtcsp_bus_sva (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic scl_oe_m,
	input wire logic sda_oe_m,
	input wire logic sda_oe_s,
	input wire logic scl,
	input wire logic sda
);
	logic [10:0] drv_cnt;
	logic [10:0] low_cnt;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			drv_cnt <= 11'h0;
		end else begin
			drv_cnt <= sda_oe_s ? drv_cnt + 11'h1 : 11'h0;
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			low_cnt <= 11'h0;
		end else begin
			low_cnt <= scl ? 11'h0 : low_cnt + 11'h1;
		end
	end
	property p_slave_moves_low;
		!$stable(sda_oe_s) |-> !scl && !$past(scl);
	endproperty
	a_slave_moves_low: assert property (p_slave_moves_low)
		else $error("slave data moved with clock high");
	property p_master_moves;
		!$stable(sda_oe_m) && scl && $past(scl) |-> !sda_oe_s;
	endproperty
	a_master_moves: assert property (p_master_moves)
		else $error("control edge while slave drives");
	property p_start_by_master;
		$fell(sda) && scl && $past(scl) |-> sda_oe_m && !$past(sda_oe_m);
	endproperty
	a_start_by_master: assert property (p_start_by_master)
		else $error("start edge not made by master");
	property p_stop_by_master;
		$rose(sda) && scl && $past(scl) |-> $past(sda_oe_m) && !$past(sda_oe_s);
	endproperty
	a_stop_by_master: assert property (p_stop_by_master)
		else $error("stop edge not made by master");
	property p_ack_held;
		sda_oe_s && $rose(scl) |-> sda_oe_s [*8];
	endproperty
	a_ack_held: assert property (p_ack_held)
		else $error("slave low not held through clock high");
	property p_slave_release;
		drv_cnt < 11'h3e8;
	endproperty
	a_slave_release: assert property (p_slave_release)
		else $error("slave holds data line too long");
	property p_scl_low_bound;
		low_cnt < 11'h0c8;
	endproperty
	a_scl_low_bound: assert property (p_scl_low_bound)
		else $error("clock low too long");
	property p_idle_after_reset;
		$rose(arst_n) |-> scl && sda && !scl_oe_m;
	endproperty
	a_idle_after_reset: assert property (p_idle_after_reset)
		else $error("bus not idle after reset");
endmodule
`default_nettype wire

/* test/tb_top.sv */
/*
 Testbench joining master and slave ends over the bus interface.
 Assumes the package recovery interval as given.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic power_fail, below_switchover, req_valid, req_read, req_set_ptr;
	logic [2:0] req_ptr;
	logic [3:0] req_count;
	logic [7:0] wr_data, rd_data;
	logic req_ready, wr_take, rd_valid, nack_seen;
	logic freeze_update, divider_reset, low_current_mode;
	logic [7:0] user_byte [8];
	logic [2:0] word_address_value;
	logic [7:0] wq [4] = '{default: 8'h00};
	logic [7:0] rq [8];
	logic fq [8];
	int wi = 0;
	int ri = 0;
	int dr_cnt = 0;
	int cyc = 0;
	int error_cnt = 0;
	int n_checks = 0;
	always #25 clk = ~clk;
	assign wr_data = wq[wi];
	rtcsp_bus_if rtcsp_bus_if_inst ();
	rtcsp_slave rtcsp_slave_inst (.clk, .arst_n, .clk_en(1'b1), .bus(rtcsp_bus_if_inst),
		.power_fail, .below_switchover, .freeze_update, .divider_reset,
		.low_current_mode, .user_byte, .word_address_value);
	rtcsp_master rtcsp_master_inst (.clk, .arst_n, .clk_en(1'b1), .bus(rtcsp_bus_if_inst),
		.req_valid, .req_ready, .req_read, .req_set_ptr, .req_ptr, .req_count,
		.wr_data, .wr_take, .rd_data, .rd_valid, .nack_seen);
	rtcsp_bus_sva rtcsp_bus_sva_inst (.clk, .arst_n, .scl_oe_m(rtcsp_bus_if_inst.scl_oe_m),
		.sda_oe_m(rtcsp_bus_if_inst.sda_oe_m), .sda_oe_s(rtcsp_bus_if_inst.sda_oe_s),
		.scl(rtcsp_bus_if_inst.scl), .sda(rtcsp_bus_if_inst.sda));
	task automatic tally_and_finish();
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	always @(posedge clk) begin
		cyc++;
		if (divider_reset === 1'b1) dr_cnt++;
		if (rd_valid === 1'b1 && ri < 8) begin
			rq[ri] = rd_data;
			fq[ri] = freeze_update;
			ri++;
		end
		if (wr_take === 1'b1) wi <= wi + 1;
		if (cyc == 80000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	task automatic wait_ready();
		while (req_ready !== 1'b1) @(posedge clk);
		#1;
	endtask
	task automatic issue(input logic rd, input logic sp, input logic [2:0] p,
		input logic [3:0] n);
		wait_ready();
		req_valid = 1'b1;
		req_read = rd;
		req_set_ptr = sp;
		req_ptr = p;
		req_count = n;
		ri = 0;
		wi = 0;
		@(posedge clk);
		while (req_ready !== 1'b1) @(posedge clk);
		#1 req_valid = 1'b0;
	endtask
	task automatic xfer(input logic rd, input logic sp, input logic [2:0] p,
		input logic [3:0] n);
		issue(rd, sp, p, n);
		repeat (4) @(posedge clk);
		wait_ready();
	endtask
	initial begin
		power_fail = 1'b0;
		below_switchover = 1'b0;
		req_valid = 1'b0;
		req_read = 1'b0;
		req_set_ptr = 1'b0;
		req_ptr = 3'h0;
		req_count = 4'h0;
		repeat (16) @(posedge clk);
		#1 arst_n = 1'b1;
		wq = '{8'ha1, 8'hb2, 8'hc3, 8'hd4};
		xfer(1'b0, 1'b0, 3'h6, 4'h4);
		chk(user_byte[6], 8'ha1);
		chk(user_byte[7], 8'hb2);
		chk(user_byte[0], 8'hc3);
		chk(user_byte[1], 8'hd4);
		chk({5'h0, word_address_value}, 8'h02);
		chk({7'h0, nack_seen}, 8'h00);
		chk(dr_cnt[7:0], 8'h01);
		chk({7'h0, freeze_update}, 8'h00);
		xfer(1'b0, 1'b0, 3'h7, 4'h0);
		xfer(1'b1, 1'b0, 3'h0, 4'h3);
		chk(rq[0], 8'hb2);
		chk(rq[1], 8'hc3);
		chk(rq[2], 8'hd4);
		chk({5'h0, word_address_value}, 8'h01);
		xfer(1'b1, 1'b1, 3'h6, 4'h2);
		chk(rq[0], 8'ha1);
		chk(rq[1], 8'hb2);
		chk({7'h0, fq[0]}, 8'h01);
		chk({7'h0, fq[1]}, 8'h00);
		chk({5'h0, word_address_value}, 8'h07);
		wq = '{8'h11, 8'h22, 8'h33, 8'h44};
		issue(1'b0, 1'b0, 3'h2, 4'h4);
		repeat (2200) @(posedge clk);
		while (rtcsp_bus_if_inst.scl !== 1'b1 || rtcsp_bus_if_inst.sda_oe_s !== 1'b0)
			@(posedge clk);
		#1 power_fail = 1'b1;
		below_switchover = 1'b1;
		wait_ready();
		chk({5'h0, word_address_value}, 8'h00);
		chk(user_byte[2], 8'h00);
		chk({7'h0, low_current_mode}, 8'h01);
		xfer(1'b1, 1'b0, 3'h0, 4'h1);
		chk({7'h0, nack_seen}, 8'h01);
		power_fail = 1'b0;
		below_switchover = 1'b0;
		wq[0] = 8'h5e;
		xfer(1'b0, 1'b0, 3'h3, 4'h1);
		chk({7'h0, nack_seen}, 8'h00);
		chk(user_byte[3], 8'h00);
		repeat (rtcsp_pkg::REC_CYCLES) @(posedge clk);
		xfer(1'b0, 1'b0, 3'h3, 4'h1);
		chk(user_byte[3], 8'h5e);
		tally_and_finish();
	end
endmodule
`default_nettype wire
